/* File: hw/rtsc_pkg.sv */
// constants, states and carrier types of the terminal status and control block
package rtsc_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] RTSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] RTSC_STATUS_OFS = 8'h04;
    localparam logic [7:0] RTSC_CONFIG_OFS = 8'h08;
    localparam logic [7:0] RTSC_XFERCNT_OFS = 8'h0c;

    // control register fields
    localparam int RTSC_CTRL_TEST_BIT = 0;
    localparam int RTSC_CTRL_TXDIS_A_BIT = 1;
    localparam int RTSC_CTRL_TXDIS_B_BIT = 2;
    localparam logic [2:0] RTSC_CTRL_RESET = 3'h0;

    // status register fields
    localparam int RTSC_STAT_STATE_LSB = 0;
    localparam int RTSC_STAT_ACTIVE_BIT = 3;
    localparam int RTSC_STAT_MIP_BIT = 4;
    localparam int RTSC_STAT_ERR_BIT = 5;
    localparam int RTSC_STAT_FAIL_BIT = 6;
    localparam int RTSC_STAT_BCAST_BIT = 7;
    localparam int RTSC_STAT_INH_BIT = 8;
    localparam int RTSC_STAT_AUTOCFG_BIT = 9;
    localparam int RTSC_STAT_CLKSEL_LSB = 10;
    localparam int RTSC_STAT_MHZ_LSB = 16;

    // auto-configuration word
    localparam logic [5:0] RTSC_CFG_RESET = 6'h00;
    localparam int RTSC_CFG_NO_TEST_BIT = 0;

    // good-transfer pulse length in clock cycles
    localparam logic [1:0] RTSC_GOOD_PULSE_CYCLES = 2'h2;

    // broadcast terminal address
    localparam logic [4:0] RTSC_BCAST_ADDR = 5'h1f;

    // clock select codes and their rates in mhz
    localparam logic [1:0] RTSC_SEL_10 = 2'h0;
    localparam logic [1:0] RTSC_SEL_20 = 2'h1;
    localparam logic [1:0] RTSC_SEL_12 = 2'h2;
    localparam logic [7:0] RTSC_MHZ_10 = 8'h0a;
    localparam logic [7:0] RTSC_MHZ_20 = 8'h14;
    localparam logic [7:0] RTSC_MHZ_12 = 8'h0c;
    localparam logic [7:0] RTSC_MHZ_16 = 8'h10;

    // value of the pin synchroniser flops under reset
    localparam logic [5:0] RTSC_SYNC_RESET = 6'h00;

    typedef enum logic [2:0] {ST_HOLD, ST_CFG, ST_TEST, ST_RUN} rtsc_state_type;

    // control pins from the subsystem, asynchronous to mclk
    typedef struct packed {
        logic [1:0] clk_sel;
        logic transmit_inhibit;
        logic broadcast_accept_en;
        logic autocfg_en_n;
        logic master_reset_n;
    } rtsc_pins_type;

    // events from the protocol engine, on mclk
    typedef struct packed {
        logic bus_active;
        logic msg_busy;
        logic cmd_valid;
        logic cmd_xfer_ok;
        logic msg_error;
        logic test_done;
        logic test_pass;
    } rtsc_evt_type;

endpackage

/* File: hw/rtsc_sync.sv */
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module rtsc_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] hold_r;
    logic [W-1:0] hold_nxt;

    always_comb
    begin
        meta_nxt = d;
        hold_nxt = meta_r;
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= RST_VAL;
            hold_r <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign q = hold_r;
endmodule

/* File: hw/rtsc_status_ctrl.sv */
// status outputs, reset and control inputs of the remote terminal
`timescale 1ns/1ps
module rtsc_status_ctrl #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins
    input wire rtsc_pkg::rtsc_pins_type ctrl_pins,
    // protocol engine
    input wire rtsc_pkg::rtsc_evt_type engine_evt,
    input wire logic cfg_ack,
    input wire logic [5:0] cfg_data,
    input wire logic cmd_addr_valid,
    input wire logic [4:0] cmd_addr,
    input wire logic [4:0] own_addr,
    output logic selftest_run,
    output logic cfg_read_req,
    output logic cmd_ours,
    output logic cmd_bcast,
    output logic tx_enable_a,
    output logic tx_enable_b,
    output logic [7:0] clock_mhz,
    // status pins
    output logic terminal_active_out,
    output logic message_in_progress_n,
    output logic good_transfer_pulse_n,
    output logic message_error_n,
    output logic selftest_failure_n
);
    import rtsc_pkg::*;

    function automatic logic is_bcast(input logic [4:0] addr,
                                      input logic en);
        is_bcast = en && (addr == RTSC_BCAST_ADDR);
    endfunction

    function automatic logic addr_hit(input logic [7:0] addr);
        if (addr == RTSC_CTRL_OFS)
            addr_hit = 1'b1;
        else if (addr == RTSC_STATUS_OFS)
            addr_hit = 1'b1;
        else if (addr == RTSC_CONFIG_OFS)
            addr_hit = 1'b1;
        else if (addr == RTSC_XFERCNT_OFS)
            addr_hit = 1'b1;
        else
            addr_hit = 1'b0;
    endfunction

    function automatic logic [7:0] sel_mhz(input logic [1:0] sel);
        if (sel == RTSC_SEL_10)
            sel_mhz = RTSC_MHZ_10;
        else if (sel == RTSC_SEL_20)
            sel_mhz = RTSC_MHZ_20;
        else if (sel == RTSC_SEL_12)
            sel_mhz = RTSC_MHZ_12;
        else
            sel_mhz = RTSC_MHZ_16;
    endfunction

    // synchronised pins
    rtsc_pins_type pins_s;
    logic mrst;

    rtsc_sync #(
        .W(6),
        .RST_VAL(RTSC_SYNC_RESET)
    ) u_pin_sync (
        .mclk(mclk),
        .resetn(resetn),
        .d(ctrl_pins),
        .q(pins_s)
    );

    assign mrst = !pins_s.master_reset_n;

    // state
    rtsc_state_type state_r, state_nxt;
    logic [5:0] cfg_r, cfg_nxt;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [CNT_W-1:0] xfer_cnt_r, xfer_cnt_nxt;
    logic [1:0] gbr_cnt_r, gbr_cnt_nxt;
    logic active_r, active_nxt;
    logic mip_n_r, mip_n_nxt;
    logic gbr_n_r, gbr_n_nxt;
    logic err_n_r, err_n_nxt;
    logic fail_n_r, fail_n_nxt;
    logic run_r, run_nxt;
    logic cfgreq_r, cfgreq_nxt;
    logic ours_r, ours_nxt;
    logic bc_r, bc_nxt;
    logic txa_r, txa_nxt;
    logic txb_r, txb_nxt;
    logic [7:0] mhz_r, mhz_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic wr_en;
    logic test_start;
    logic [31:0] status_w;

    assign wr_en = psel && penable && pwrite && pready_r;
    assign test_start = wr_en && (paddr == RTSC_CTRL_OFS)
        && pwdata[RTSC_CTRL_TEST_BIT];

    // terminal sequencing
    always_comb
    begin
        state_nxt = state_r;
        cfg_nxt = cfg_r;
        case (state_r)
            ST_HOLD:
                if (pins_s.autocfg_en_n)
                    state_nxt = ST_TEST;
                else
                    state_nxt = ST_CFG;
            ST_CFG:
                if (cfg_ack)
                begin
                    cfg_nxt = cfg_data;
                    if (cfg_data[RTSC_CFG_NO_TEST_BIT])
                        state_nxt = ST_RUN;
                    else
                        state_nxt = ST_TEST;
                end
            ST_TEST:
                if (engine_evt.test_done)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (test_start)
                    state_nxt = ST_TEST;
            default:
                state_nxt = ST_HOLD;
        endcase
        if (mrst)
        begin
            state_nxt = ST_HOLD;
            cfg_nxt = RTSC_CFG_RESET;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= ST_HOLD;
            cfg_r <= RTSC_CFG_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    // status pins and engine controls
    always_comb
    begin
        active_nxt = (state_r == ST_RUN) && engine_evt.bus_active
            && !mrst;
        mip_n_nxt = !(engine_evt.msg_busy && !mrst);
        gbr_cnt_nxt = gbr_cnt_r;
        if (mrst)
            gbr_cnt_nxt = 2'h0;
        else if (engine_evt.cmd_xfer_ok)
            gbr_cnt_nxt = RTSC_GOOD_PULSE_CYCLES;
        else if (gbr_cnt_r != 2'h0)
            gbr_cnt_nxt = gbr_cnt_r - 2'h1;
        gbr_n_nxt = (gbr_cnt_nxt == 2'h0);
        err_n_nxt = err_n_r;
        if (mrst)
            err_n_nxt = 1'b1;
        else if (engine_evt.msg_error)
            err_n_nxt = 1'b0;
        else if (engine_evt.cmd_valid)
            err_n_nxt = 1'b1;
        fail_n_nxt = fail_n_r;
        if (mrst)
            fail_n_nxt = 1'b1;
        else if ((state_r == ST_TEST) && engine_evt.test_done)
            fail_n_nxt = engine_evt.test_pass;
        run_nxt = (state_nxt == ST_TEST);
        cfgreq_nxt = (state_nxt == ST_CFG);
        bc_nxt = cmd_addr_valid
            && is_bcast(cmd_addr, pins_s.broadcast_accept_en);
        ours_nxt = cmd_addr_valid && ((cmd_addr == own_addr)
            || is_bcast(cmd_addr, pins_s.broadcast_accept_en));
        txa_nxt = !pins_s.transmit_inhibit && !mrst
            && !ctrl_r[RTSC_CTRL_TXDIS_A_BIT];
        txb_nxt = !pins_s.transmit_inhibit && !mrst
            && !ctrl_r[RTSC_CTRL_TXDIS_B_BIT];
        mhz_nxt = sel_mhz(pins_s.clk_sel);
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            active_r <= 1'b0;
            mip_n_r <= 1'b1;
            gbr_cnt_r <= 2'h0;
            gbr_n_r <= 1'b1;
            err_n_r <= 1'b1;
            fail_n_r <= 1'b1;
            run_r <= 1'b0;
            cfgreq_r <= 1'b0;
            bc_r <= 1'b0;
            ours_r <= 1'b0;
            txa_r <= 1'b0;
            txb_r <= 1'b0;
            mhz_r <= RTSC_MHZ_10;
        end
        else
        begin
            active_r <= active_nxt;
            mip_n_r <= mip_n_nxt;
            gbr_cnt_r <= gbr_cnt_nxt;
            gbr_n_r <= gbr_n_nxt;
            err_n_r <= err_n_nxt;
            fail_n_r <= fail_n_nxt;
            run_r <= run_nxt;
            cfgreq_r <= cfgreq_nxt;
            bc_r <= bc_nxt;
            ours_r <= ours_nxt;
            txa_r <= txa_nxt;
            txb_r <= txb_nxt;
            mhz_r <= mhz_nxt;
        end
    end

    // status word
    always_comb
    begin
        status_w = 32'h0;
        status_w[RTSC_STAT_STATE_LSB +: 3] = 3'(state_r);
        status_w[RTSC_STAT_ACTIVE_BIT] = active_r;
        status_w[RTSC_STAT_MIP_BIT] = !mip_n_r;
        status_w[RTSC_STAT_ERR_BIT] = !err_n_r;
        status_w[RTSC_STAT_FAIL_BIT] = !fail_n_r;
        status_w[RTSC_STAT_BCAST_BIT] = pins_s.broadcast_accept_en;
        status_w[RTSC_STAT_INH_BIT] = pins_s.transmit_inhibit;
        status_w[RTSC_STAT_AUTOCFG_BIT] = !pins_s.autocfg_en_n;
        status_w[RTSC_STAT_CLKSEL_LSB +: 2] = pins_s.clk_sel;
        status_w[RTSC_STAT_MHZ_LSB +: 8] = mhz_r;
    end

    // apb registers
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        xfer_cnt_nxt = xfer_cnt_r;
        if (engine_evt.cmd_xfer_ok)
            xfer_cnt_nxt = xfer_cnt_r + 1'b1;
        if (wr_en && (paddr == RTSC_CTRL_OFS))
        begin
            ctrl_nxt = pwdata[2:0];
            ctrl_nxt[RTSC_CTRL_TEST_BIT] = 1'b0;
        end
        else if (wr_en && (paddr == RTSC_XFERCNT_OFS))
            xfer_cnt_nxt = '0;
        if (mrst)
        begin
            ctrl_nxt = RTSC_CTRL_RESET;
            xfer_cnt_nxt = '0;
        end
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !addr_hit(paddr);
        prdata_nxt = prdata_r;
        if (psel && !penable)
        begin
            if (paddr == RTSC_CTRL_OFS)
                prdata_nxt = {29'h0, ctrl_r};
            else if (paddr == RTSC_STATUS_OFS)
                prdata_nxt = status_w;
            else if (paddr == RTSC_CONFIG_OFS)
                prdata_nxt = {26'h0, cfg_r};
            else if (paddr == RTSC_XFERCNT_OFS)
                prdata_nxt = 32'(xfer_cnt_r);
            else
                prdata_nxt = 32'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_r <= RTSC_CTRL_RESET;
            xfer_cnt_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            xfer_cnt_r <= xfer_cnt_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign selftest_run = run_r;
    assign cfg_read_req = cfgreq_r;
    assign cmd_ours = ours_r;
    assign cmd_bcast = bc_r;
    assign tx_enable_a = txa_r;
    assign tx_enable_b = txb_r;
    assign clock_mhz = mhz_r;
    assign terminal_active_out = active_r;
    assign message_in_progress_n = mip_n_r;
    assign good_transfer_pulse_n = gbr_n_r;
    assign message_error_n = err_n_r;
    assign selftest_failure_n = fail_n_r;

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence xfer_alone;
        (engine_evt.cmd_xfer_ok && !mrst) ##1
            (!engine_evt.cmd_xfer_ok && !mrst)[*2];
    endsequence

    active_run_a: assert property (
        (state_r == ST_RUN) && engine_evt.bus_active && !mrst
        |=> terminal_active_out)
        else $error("activity output not high while running");
    active_quiet_a: assert property (
        (state_r == ST_TEST) || (state_r == ST_CFG)
        |=> !terminal_active_out)
        else $error("activity output high during test or config");
    msg_progress_a: assert property (
        ##1 (message_in_progress_n == !$past(engine_evt.msg_busy && !mrst)))
        else $error("message in progress output wrong");
    good_pulse_a: assert property (
        (engine_evt.cmd_xfer_ok && !mrst)
        |=> !good_transfer_pulse_n
        ##1 (!good_transfer_pulse_n || $past(mrst)))
        else $error("good transfer pulse shorter than two clocks");
    good_end_a: assert property (
        xfer_alone |=> good_transfer_pulse_n)
        else $error("good transfer pulse longer than two clocks");
    err_set_a: assert property (
        engine_evt.msg_error && !mrst |=> !message_error_n)
        else $error("message error not flagged");
    err_hold_a: assert property (
        !message_error_n && !engine_evt.cmd_valid && !mrst
        |=> !message_error_n)
        else $error("message error dropped without cause");
    err_clear_a: assert property (
        (engine_evt.cmd_valid && !engine_evt.msg_error) || mrst
        |=> message_error_n)
        else $error("message error not cleared");
    fail_flag_a: assert property (
        (state_r == ST_TEST) && engine_evt.test_done
        && !engine_evt.test_pass && !mrst
        |=> !selftest_failure_n && (state_r == ST_RUN))
        else $error("self-test failure not reported");
    mreset_a: assert property (
        mrst |=> (state_r == ST_HOLD) && message_error_n
        && !tx_enable_a ##1 ((state_r == ST_HOLD) || !$past(mrst)))
        else $error("master reset did not hold the terminal");
    autocfg_a: assert property (
        (state_r == ST_HOLD) && !mrst && !pins_s.autocfg_en_n
        |=> cfg_read_req && (state_r == ST_CFG))
        else $error("auto-configuration not started");
    cfg_take_a: assert property (
        (state_r == ST_CFG) && cfg_ack && !mrst
        |=> (cfg_r == $past(cfg_data)) && !cfg_read_req)
        else $error("configuration word not taken");
    cfg_skip_a: assert property (
        (state_r == ST_HOLD) && !mrst && pins_s.autocfg_en_n
        |=> (state_r == ST_TEST) && !cfg_read_req)
        else $error("auto-configuration not skipped");
    bcast_a: assert property (
        cmd_addr_valid && (cmd_addr == RTSC_BCAST_ADDR)
        |=> cmd_bcast == $past(pins_s.broadcast_accept_en))
        else $error("broadcast address handling wrong");
    tx_inhibit_a: assert property (
        pins_s.transmit_inhibit |=> !tx_enable_a && !tx_enable_b)
        else $error("transmitters not shut down");
    clk_sel_a: assert property (
        pins_s.clk_sel == RTSC_SEL_20 |=> clock_mhz == RTSC_MHZ_20)
        else $error("clock select decoded wrong");
endmodule

/* File: bench/rtsc_subsys_model.sv */
// subsystem model: drives the control pins, watches the good-transfer pin
`timescale 1ns/1ps
module rtsc_subsys_model (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // pin levels asked for by the bench
    input wire rtsc_pkg::rtsc_pins_type want,
    output rtsc_pkg::rtsc_pins_type ctrl_pins,
    // watched status pin and its measured pulses
    input wire logic good_transfer_pulse_n,
    output logic [7:0] pulse_len,
    output logic [7:0] pulse_cnt
);
    import rtsc_pkg::*;

    logic [7:0] run_r;

    // pins low under reset, so the terminal starts held in master reset
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_pins <= '0;
            run_r <= 8'h00;
            pulse_len <= 8'h00;
            pulse_cnt <= 8'h00;
        end
        else
        begin
            ctrl_pins <= want;
            if (!good_transfer_pulse_n)
                run_r <= run_r + 8'h01;
            else if (run_r != 8'h00)
            begin
                pulse_len <= run_r;
                pulse_cnt <= pulse_cnt + 8'h01;
                run_r <= 8'h00;
            end
        end
    end
endmodule

/* File: bench/rtsc_status_ctrl_tb.sv */
// self-checking bench of the terminal status and control block
`timescale 1ns/1ps
module rtsc_status_ctrl_tb;
    import rtsc_pkg::*;

    logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, clock_mhz, pulse_len, pulse_cnt;
    logic [31:0] pwdata, prdata, rd, seed, r;
    logic cfg_ack, cmd_addr_valid, selftest_run, cfg_read_req;
    logic cmd_ours, cmd_bcast, tx_enable_a, tx_enable_b;
    logic [5:0] cfg_data, cfg_word;
    logic [4:0] cmd_addr, own_addr, a;
    logic act, mip_n, good_n, err_n, fail_n, en, perr;
    rtsc_pins_type want, pins;
    rtsc_evt_type evt;
    int errors, cmp_count, cycles;

    rtsc_status_ctrl #(.CNT_W(16)) DUT (.mclk(mclk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ctrl_pins(pins), .engine_evt(evt),
        .cfg_ack(cfg_ack), .cfg_data(cfg_data),
        .cmd_addr_valid(cmd_addr_valid), .cmd_addr(cmd_addr),
        .own_addr(own_addr), .selftest_run(selftest_run),
        .cfg_read_req(cfg_read_req), .cmd_ours(cmd_ours),
        .cmd_bcast(cmd_bcast), .tx_enable_a(tx_enable_a),
        .tx_enable_b(tx_enable_b), .clock_mhz(clock_mhz),
        .terminal_active_out(act), .message_in_progress_n(mip_n),
        .good_transfer_pulse_n(good_n), .message_error_n(err_n),
        .selftest_failure_n(fail_n));

    rtsc_subsys_model partner (.mclk(mclk), .resetn(resetn), .want(want),
        .ctrl_pins(pins), .good_transfer_pulse_n(good_n),
        .pulse_len(pulse_len), .pulse_cnt(pulse_cnt));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_mhz(input logic [1:0] s);
        case (s)
            2'h0: return 8'h0a;
            2'h1: return 8'h14;
            2'h2: return 8'h0c;
            default: return 8'h10;
        endcase
    endfunction

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one apb transfer, waits for pready; the bench timeout bounds it
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle engine event pulse
    task automatic ev(input rtsc_evt_type m);
        @(posedge mclk);
        evt <= evt | m;
        @(posedge mclk);
        evt <= evt & ~m;
        #1;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end

    initial
    begin
        seed = 32'd91381;
        {resetn, psel, penable, pwrite, cfg_ack, cmd_addr_valid} = '0;
        paddr = 8'h00;
        pwdata = '0;
        cfg_data = 6'h00;
        cmd_addr = 5'h00;
        own_addr = 5'h00;
        evt = '0;
        want = '{2'h0, 1'b0, 1'b0, 1'b1, 1'b0};
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (16) @(posedge mclk);
        resetn <= 1'b1;
        cyc(2);
        check("fail_n", 1, fail_n);
        check("err_n", 1, err_n);
        apb(1'b0, 8'h10, '0);
        check("slverr", 1, perr);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            want.clk_sel <= 2'(i);
            cyc(5);
            check("mhz", exp_mhz(2'(i)), clock_mhz);
        end
        // self-test path, auto-configuration off
        @(posedge mclk);
        evt.bus_active <= 1'b1;
        want.master_reset_n <= 1'b1;
        cyc(6);
        check("test_run", 1, selftest_run);
        check("cfg_req", 0, cfg_read_req);
        check("active", 0, act);
        ev(7'h02);
        check("fail_n", 0, fail_n);
        @(posedge mclk);
        want.master_reset_n <= 1'b0;
        want.autocfg_en_n <= 1'b0;
        cyc(5);
        check("fail_n", 1, fail_n);
        // auto-configuration path
        @(posedge mclk);
        want.master_reset_n <= 1'b1;
        cyc(6);
        check("cfg_req", 1, cfg_read_req);
        check("active", 0, act);
        r = xs();
        cfg_word = {r[4:0], 1'b1};
        @(posedge mclk);
        cfg_ack <= 1'b1;
        cfg_data <= cfg_word;
        @(posedge mclk);
        cfg_ack <= 1'b0;
        cyc(2);
        check("active", 1, act);
        apb(1'b0, RTSC_CONFIG_OFS, '0);
        check("config", {26'h0, cfg_word}, rd);
        @(posedge mclk);
        evt.bus_active <= 1'b0;
        evt.msg_busy <= 1'b1;
        cyc(2);
        check("active", 0, act);
        check("mip_n", 0, mip_n);
        @(posedge mclk);
        evt.msg_busy <= 1'b0;
        cyc(2);
        check("mip_n", 1, mip_n);
        ev(7'h08);
        cyc(4);
        check("pulse_len", 2, pulse_len);
        check("pulse_cnt", 1, pulse_cnt);
        ev(7'h04);
        cyc(5);
        check("err_n", 0, err_n);
        ev(7'h10);
        check("err_n", 1, err_n);
        check("tx_a", 1, tx_enable_a);
        @(posedge mclk);
        want.transmit_inhibit <= 1'b1;
        cyc(5);
        check("tx_a", 0, tx_enable_a);
        check("tx_b", 0, tx_enable_b);
        r = xs();
        @(posedge mclk);
        want.transmit_inhibit <= 1'b0;
        own_addr <= 5'(r % 31);
        for (int i = 0; i < 8; i++)
        begin
            r = xs();
            en = (i == 0) ? 1'b0 : ((i < 3) ? 1'b1 : r[5]);
            a = (i < 2) ? 5'h1f : ((i == 2) ? own_addr : r[4:0]);
            @(posedge mclk);
            want.broadcast_accept_en <= en;
            cyc(5);
            @(posedge mclk);
            cmd_addr_valid <= 1'b1;
            cmd_addr <= a;
            @(posedge mclk);
            cmd_addr_valid <= 1'b0;
            #1;
            check("bcast", en && a == 5'h1f, cmd_bcast);
            check("ours", (en && a == 5'h1f) || a == own_addr,
                  cmd_ours);
        end
        ev(7'h04);
        apb(1'b1, RTSC_CTRL_OFS, 32'h3);
        cyc(2);
        check("test_run", 1, selftest_run);
        check("tx_a", 0, tx_enable_a);
        check("tx_b", 1, tx_enable_b);
        apb(1'b0, RTSC_XFERCNT_OFS, '0);
        check("xfercnt", 1, rd);
        @(posedge mclk);
        want.master_reset_n <= 1'b0;
        cyc(5);
        check("err_n", 1, err_n);
        end_sim();
    end
endmodule
